//--- sfs_pkg.sv
/*
 * Shared constants for the serial ferroelectric memory slave front end:
 * opcodes, status layout, array size, timing figures and reset values.
 * Assumes the importing modules run on a single 200 MHz system clock.
 */
package sfs_pkg;

  // Array geometry
  localparam int SFS_ADDR_W = 9;
  localparam int SFS_DATA_W = 8;
  localparam int SFS_WORDS = 512;
  localparam int SFS_FIFO_DEPTH = 4;
  localparam int SFS_FIFO_W = SFS_ADDR_W + SFS_DATA_W;

  // Protected regions by block-protect code
  localparam logic [8:0] SFS_QUARTER_BASE = 9'h180;
  localparam logic [8:0] SFS_HALF_BASE = 9'h100;

  // Opcodes; bit 3 of read/write carries the upper address bit
  localparam logic [7:0] SFS_OP_WREN = 8'h06;
  localparam logic [7:0] SFS_OP_WRDI = 8'h04;
  localparam logic [7:0] SFS_OP_RDSR = 8'h05;
  localparam logic [7:0] SFS_OP_WRSR = 8'h01;
  localparam logic [7:0] SFS_OP_READ = 8'h03;
  localparam logic [7:0] SFS_OP_WRITE = 8'h02;
  localparam logic [7:0] SFS_OP_A8_MASK = 8'h08;
  localparam int SFS_OP_A8_BIT = 3;

  // Status register layout
  localparam int SFS_SR_WEL = 1;
  localparam int SFS_SR_BP_LO = 2;
  localparam int SFS_SR_BP_HI = 3;

  // Reset values
  localparam logic [1:0] SFS_BP_RST = 2'h0;
  localparam logic [7:0] SFS_MEM_RST = 8'h00;
  localparam logic [4:0] SFS_PINS_RST = 5'h1F;

  // Timing: fastest serial clock and system clock, in MHz
  localparam int SFS_SCK_MAX_MHZ = 20;
  localparam int SFS_SYS_MHZ = 200;
  localparam int SFS_SYS_PER_SCK = SFS_SYS_MHZ / SFS_SCK_MAX_MHZ;

  typedef enum logic [2:0] {
    SFS_IDLE,
    SFS_OPC,
    SFS_ADDR,
    SFS_WDATA,
    SFS_RDATA,
    SFS_SRW,
    SFS_SRR,
    SFS_IGN
  } sfs_state_t;

endpackage : sfs_pkg

//--- sfs_fifo.sv
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module sfs_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } sfs_fifo_st_t;

  sfs_fifo_st_t s_q, s_d;
  logic push, pop;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : inc

  assign in_ready = (s_q.cnt != CW'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = s_q.mem[s_q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = inc(s_q.wp);
    end
    if (pop) begin
      s_d.rp = inc(s_q.rp);
    end
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + CW'(1);
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sfs_fifo

//--- sfs_top.sv
/*
 * Serial memory slave: oversamples the serial clock, chip select, data
 * and control pins, decodes commands and keeps a 512-byte array with
 * write protection. Written bytes pass a small FIFO before the array.
 * Assumes the system clock is at least ten times the serial clock.
 */
`timescale 1ns/1ps
// What this block does
// - Selected only while chip select is low; serial clock used then only.
// - Chip select high: standby, inputs ignored, output released.
// - Each chip select falling edge outside a pause starts a fresh command.
// - Sample input on rising serial clock, change output on falling.
// - Any serial clock rate up to 20 MHz; state held when stopped.
// - Output driven only for read data, never during pause.
// - Write protect low blocks every write, status included.
// - Write protect high: status protection settings decide writes.
// - Pause low suspends the transfer; resumes where it left off.
// - During pause, serial clock and chip select edges are ignored.
// - Array holds 512 bytes, one per 9-bit address.
// - Each byte committed right after its last bit, no busy time.
// - Works in SPI mode 0 and mode 3.
// - Block protect makes upper quarter, half or whole array read-only.
// - Write disable clears write permission until re-enabled.
// - First eight bits after select are the opcode.
// - Unknown opcode: ignore rest of command, output stays released.
// - MSB first; address bit 8 rides in opcode, then 8-bit address.
// - Serial clock level at select picks mode 0 or mode 3.
module sfs_top
  import sfs_pkg::*;
#(
  parameter int FIFO_DEPTH = sfs_pkg::SFS_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Serial link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  output logic so_o,
  output logic so_oe,
  // Protection and pause pins
  input wire logic wp_n,
  input wire logic hold_n,
  // Status view
  output logic standby,
  output logic mode3,
  output logic [7:0] status
);

  import sfs_pkg::*;

  typedef struct packed {
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic sck_p;
    logic sel;
    logic mode3;
    sfs_state_t state;
    logic [7:0] shift;
    logic [2:0] bcnt;
    logic a8;
    logic rd;
    logic [SFS_ADDR_W-1:0] addr;
    logic [7:0] tx;
    logic so;
    logic so_en;
    logic wel;
    logic [1:0] bp;
    logic wrote;
    logic pend;
    logic [SFS_FIFO_W-1:0] pend_w;
    logic [SFS_WORDS-1:0][7:0] mem;
  } sfs_st_t;

  sfs_st_t s_q, s_d;

  // Synchronised pin levels
  logic cs_l, sck_l, si_l, wp_l, hold_l;
  logic held, rise, fall;
  logic [7:0] nb;
  logic [7:0] sr_byte;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [SFS_FIFO_W-1:0] fifo_out_data;

  // True when addr falls inside the region the block-protect code covers
  function automatic logic is_protected(input logic [8:0] a,
                                        input logic [1:0] bp);
    case (bp)
      2'h0: is_protected = 1'b0;
      2'h1: is_protected = (a >= SFS_QUARTER_BASE);
      2'h2: is_protected = (a >= SFS_HALF_BASE);
      default: is_protected = 1'b1;
    endcase
  endfunction : is_protected

  // Clear the upper address bit so read/write match their base opcode
  function automatic logic [7:0] base_op(input logic [7:0] op);
    base_op = op & ~SFS_OP_A8_MASK;
  endfunction : base_op

  assign cs_l = s_q.pin_s2[4];
  assign sck_l = s_q.pin_s2[3];
  assign si_l = s_q.pin_s2[2];
  assign wp_l = s_q.pin_s2[1];
  assign hold_l = s_q.pin_s2[0];

  assign held = !hold_l;
  // Edges only count while selected and not paused
  assign rise = s_q.sel && !held && sck_l && !s_q.sck_p;
  assign fall = s_q.sel && !held && !sck_l && s_q.sck_p;
  assign nb = {s_q.shift[6:0], si_l};

  always_comb begin
    sr_byte = 8'h00;
    sr_byte[SFS_SR_WEL] = s_q.wel;
    sr_byte[SFS_SR_BP_HI:SFS_SR_BP_LO] = s_q.bp;
  end

  // Array write port stalls on serial rising edges, when reads load
  assign fifo_out_ready = !rise;

  sfs_fifo #(
    .WIDTH(SFS_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_valid(s_q.pend),
    .in_ready(fifo_in_ready),
    .in_data(s_q.pend_w),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  always_comb begin
    s_d = s_q;
    // Two stages before anything looks at a pin
    s_d.pin_s1 = {cs_n, sck, si, wp_n, hold_n};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.sck_p = sck_l;

    // Pending byte leaves once the FIFO takes it
    if (s_q.pend && fifo_in_ready) begin
      s_d.pend = 1'b0;
    end

    // Drain into the array
    if (fifo_out_valid && fifo_out_ready) begin
      s_d.mem[fifo_out_data[SFS_FIFO_W-1:SFS_DATA_W]] =
        fifo_out_data[SFS_DATA_W-1:0];
    end

    if (!held) begin
      if (!s_q.sel && !cs_l) begin
        // New command; clock level tells the mode
        s_d.sel = 1'b1;
        s_d.mode3 = sck_l;
        s_d.state = SFS_OPC;
        s_d.bcnt = 3'h0;
        s_d.so_en = 1'b0;
        s_d.wrote = 1'b0;
      end else if (s_q.sel && cs_l) begin
        // Deselect drops any partial byte and ends the command
        s_d.sel = 1'b0;
        s_d.state = SFS_IDLE;
        s_d.bcnt = 3'h0;
        s_d.so_en = 1'b0;
        if (s_q.wrote) begin
          s_d.wel = 1'b0;
        end
        s_d.wrote = 1'b0;
      end
    end

    if (rise && s_q.state != SFS_IGN) begin
      s_d.shift = nb;
      s_d.bcnt = s_q.bcnt + 3'h1;
      if (s_q.bcnt == 3'h7) begin
        case (s_q.state)
          SFS_OPC: begin
            s_d.a8 = nb[SFS_OP_A8_BIT];
            if (nb == SFS_OP_WREN) begin
              s_d.wel = 1'b1;
              s_d.state = SFS_IGN;
            end else if (nb == SFS_OP_WRDI) begin
              s_d.wel = 1'b0;
              s_d.state = SFS_IGN;
            end else if (nb == SFS_OP_RDSR) begin
              s_d.tx = sr_byte;
              s_d.state = SFS_SRR;
            end else if (nb == SFS_OP_WRSR) begin
              s_d.state = SFS_SRW;
            end else if (base_op(nb) == SFS_OP_READ) begin
              s_d.rd = 1'b1;
              s_d.state = SFS_ADDR;
            end else if (base_op(nb) == SFS_OP_WRITE) begin
              s_d.rd = 1'b0;
              s_d.state = SFS_ADDR;
            end else begin
              s_d.state = SFS_IGN;
            end
          end
          SFS_ADDR: begin
            s_d.addr = {s_q.a8, nb};
            if (s_q.rd) begin
              s_d.tx = s_q.mem[{s_q.a8, nb}];
              s_d.addr = {s_q.a8, nb} + 9'h001;
              s_d.state = SFS_RDATA;
            end else begin
              s_d.state = SFS_WDATA;
            end
          end
          SFS_WDATA: begin
            // Hardware pin, latch and block protect all gate the write
            if (wp_l && s_q.wel &&
                !is_protected(s_q.addr, s_q.bp)) begin
              s_d.pend = 1'b1;
              s_d.pend_w = {s_q.addr, nb};
              s_d.wrote = 1'b1;
            end
            s_d.addr = s_q.addr + 9'h001;
          end
          SFS_RDATA: begin
            s_d.tx = s_q.mem[s_q.addr];
            s_d.addr = s_q.addr + 9'h001;
          end
          SFS_SRW: begin
            if (wp_l && s_q.wel) begin
              s_d.bp = nb[SFS_SR_BP_HI:SFS_SR_BP_LO];
              s_d.wrote = 1'b1;
            end
            s_d.state = SFS_IGN;
          end
          SFS_SRR: begin
            s_d.tx = sr_byte;
          end
          default: begin
            s_d.state = SFS_IGN;
          end
        endcase
      end
    end

    // Output bits move only on falling edges, only in read phases
    if (fall && (s_q.state == SFS_RDATA || s_q.state == SFS_SRR)) begin
      s_d.so = s_q.tx[7];
      s_d.tx = {s_q.tx[6:0], 1'b0};
      s_d.so_en = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.pin_s1 <= SFS_PINS_RST;
      s_q.pin_s2 <= SFS_PINS_RST;
      s_q.state <= SFS_IDLE;
      s_q.bp <= SFS_BP_RST;
      s_q.mem <= {SFS_WORDS{SFS_MEM_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Released when deselected, paused or not returning data
  // Pin level too: a deselect made during a pause releases at once
  assign so_oe = s_q.so_en && s_q.sel && !held &&
    !cs_l;
  assign so_o = s_q.so;
  assign standby = !s_q.sel;
  assign mode3 = s_q.mode3;
  assign status = sr_byte;

endmodule : sfs_top

//--- sfs_top_asserts.sv
/* Pin checker for sfs_top.
   Bound into sfs_top; sees its ports only, one clock domain. */
`timescale 1ns/1ps
module sfs_top_asserts #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Serial and control pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic hold_n,
  // Status view
  input wire logic standby,
  input wire logic mode3,
  input wire logic [7:0] status
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_oe_sel; so_oe |-> !standby && !$past(cs_n, 2); endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("output driven while unselected");
  property p_stby; (cs_n && hold_n) [*6] |-> standby; endproperty
  a_stby: assert property (p_stby)
    else $error("no standby while deselected");
  property p_oe_cs; (cs_n && hold_n) [*6] |-> !so_oe; endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("output not released on deselect");
  property p_oe_hold; (!hold_n) [*4] |-> !so_oe; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("output driven during pause");
  property p_so_fall;
    $changed(so_o) && so_oe && $past(so_oe) |-> !$past(sck);
  endproperty
  a_so_fall: assert property (p_so_fall)
    else $error("output changed after a rising clock");
  property p_hold_so; (!hold_n) [*3] |=> $stable(so_o); endproperty
  a_hold_so: assert property (p_hold_so)
    else $error("output moved during pause");
  property p_wp_sr; (!wp_n) [*4] |=> $stable(status[3:2]); endproperty
  a_wp_sr: assert property (p_wp_sr)
    else $error("protect bits changed while write protected");
  property p_mode; !standby && !$past(standby) |-> $stable(mode3); endproperty
  a_mode: assert property (p_mode)
    else $error("mode changed inside a command");
endmodule : sfs_top_asserts

bind sfs_top sfs_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si),
  .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n),
  .standby(standby), .mode3(mode3), .status(status));

//--- sfs_master.sv
/* Behavioural SPI master for the serial memory slave.
   Driven by the bench through its tasks; half period 32 ns. */
`timescale 1ns/1ps
module sfs_master (
  // Pins driven
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  // Pins seen
  input wire logic so_o,
  input wire logic so_oe
);
  localparam time HALF = 32ns;
  logic m3 = 1'b0;
  // Released line reads as the inverse of the last output bit, never a stale one
  wire so_line = so_oe ? so_o : ~so_o;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic sel(input logic mode);
    m3 = mode;
    sck = mode;
    #HALF cs_n = 1'b0;
    #HALF;
  endtask : sel
  task automatic xfer(input logic [7:0] b, input int n,
                      output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      si = b[7 - i];
      #HALF sck = 1'b1;
      r[7 - i] = so_line;
      #HALF;
    end
    if (!m3) sck = 1'b0;
  endtask : xfer
  task automatic desel();
    #HALF cs_n = 1'b1;
    si = ~si;
    #HALF;
  endtask : desel
  // Clock and select wiggle while paused; must leave no trace
  task automatic pause();
    // Let the last falling edge land first, or its output bit is lost
    #HALF hold_n = 1'b0;
    repeat (2) begin
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
    cs_n = 1'b1;
    #HALF cs_n = 1'b0;
    #HALF hold_n = 1'b1;
    #HALF;
  endtask : pause
endmodule : sfs_master

//--- sfs_top_bench.sv
/* Bench for sfs_top: corner and random commands via sfs_master,
   checked against a byte model. Needs sfs_pkg and the checker. */
`timescale 1ns/1ps
module sfs_top_bench;
  import sfs_pkg::*;
  logic sys_clk, arst_n, cs_n, sck, si, so_o, so_oe, wp_n, hold_n;
  logic standby, mode3, m;
  logic [7:0] status, r, d0, d1;
  logic [7:0] mem [SFS_WORDS];
  logic [1:0] bp;
  logic [8:0] a;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 21;
  sfs_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n),
    .standby(standby), .mode3(mode3), .status(status));
  sfs_master u_m (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .so_o(so_o), .so_oe(so_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  function automatic logic [7:0] opc(input logic [7:0] op);
    return op | (a[8] ? SFS_OP_A8_MASK : 8'h00);
  endfunction : opc
  function automatic logic may_write(input logic [8:0] ad);
    return wp_n && (bp == 2'h0 || (bp == 2'h1 && ad < SFS_QUARTER_BASE)
      || (bp == 2'h2 && ad < SFS_HALF_BASE));
  endfunction : may_write
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n);
    u_m.sel(m);
    check(8'(mode3), 8'(m));
    check(8'(standby), 8'h00);
    u_m.xfer(op, 8, r);
    if (n > 0) u_m.xfer(arg, n, r);
    u_m.desel();
  endtask : cmd
  // Head of a write: opcode, then word address
  task automatic whead();
    u_m.sel(m);
    u_m.xfer(opc(SFS_OP_WRITE), 8, r);
    u_m.xfer(a[7:0], 8, r);
  endtask : whead
  task automatic wr(input logic ok);
    whead();
    u_m.xfer(d0, 8, r);
    u_m.xfer(d1, 8, r);
    u_m.desel();
    if (ok && may_write(a)) mem[a] = d0;
    if (ok && may_write(a + 9'h001)) mem[a + 9'h001] = d1;
  endtask : wr
  task automatic rd(input logic hp);
    u_m.sel(m);
    u_m.xfer(opc(SFS_OP_READ), 8, r);
    u_m.xfer(a[7:0], 8, r);
    u_m.xfer(8'h00, 8, r);
    check(r, mem[a]);
    if (hp) u_m.pause();
    u_m.xfer(8'h00, 8, r);
    check(r, mem[a + 9'h001]);
    u_m.desel();
  endtask : rd
  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    m = 1'b0;
    a = 9'h055;
    d0 = 8'hA5;
    d1 = 8'h5A;
    bp = SFS_BP_RST;
    foreach (mem[i]) mem[i] = SFS_MEM_RST;
    repeat (20) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    check(status, 8'h00);
    check(8'(standby), 8'h01);
    wr(1'b0);
    cmd(SFS_OP_WREN, 8'h00, 0);
    check(status, 8'h01 << SFS_SR_WEL);
    cmd(SFS_OP_WRDI, 8'h00, 0);
    check(status, 8'h00);
    wr(1'b0);
    rd(1'b0);
    u_m.sel(m);
    u_m.xfer(8'hFF, 8, r);
    u_m.xfer(SFS_OP_READ, 8, r);
    check(8'(so_oe), 8'h00);
    u_m.desel();
    cmd(SFS_OP_WREN, 8'h00, 0);
    whead();
    u_m.xfer(8'hC3, 5, r);
    u_m.desel();
    rd(1'b0);
    for (int k = 0; k < 16; k++) begin
      m = 1'($random(seed));
      a = (k == 0) ? 9'h1FF : 9'($random(seed));
      d0 = 8'($random(seed));
      d1 = 8'($random(seed));
      @(posedge sys_clk);
      #1 wp_n = (k < 4) ? 1'b1 : 1'($random(seed));
      cmd(SFS_OP_WREN, 8'h00, 0);
      cmd(SFS_OP_WRSR, {4'h0, 2'(k), 2'h0}, 8);
      if (wp_n) bp = 2'(k);
      cmd(SFS_OP_RDSR, 8'h00, 8);
      check(r & 8'h0C, {4'h0, bp, 2'h0});
      cmd(SFS_OP_WREN, 8'h00, 0);
      wr(1'b1);
      rd(1'b0);
    end
    m = 1'b0;
    rd(1'b1);
    stop_test();
  end
  initial begin
    #400us;
    n_errors++;
    stop_test();
  end
endmodule : sfs_top_bench
